// ===== ref_select_pkg.sv
// ref_select_pkg: constants and carrier types for the reference selector
// assumes a 10 MHz pclk and a 32-bit APB register port
package ref_select_pkg;

	// ----------------------------------------------------------------
	// register map (byte offsets)
	// ----------------------------------------------------------------
	localparam logic [11:0] ctrl_addr = 12'h000;
	localparam logic [11:0] prio_addr = 12'h004;
	localparam logic [11:0] mon_en_addr = 12'h008;
	localparam logic [11:0] vtimer0_addr = 12'h00C;
	localparam logic [11:0] vtimer1_addr = 12'h010;
	localparam logic [11:0] slew_addr = 12'h014;
	localparam logic [11:0] status_addr = 12'h018;
	localparam logic [11:0] flags_addr = 12'h01C;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int ctrl_mode_lsb = 0; // 2 bits
	localparam int ctrl_man_lsb = 2; // manual_ref_choice
	localparam int ctrl_pinsel_lsb = 3; // use pin instead of field
	localparam int ctrl_osc_byp_lsb = 4; // osc_detect_bypass
	localparam int ctrl_cancel_lsb = 5; // phase cancellation enable
	localparam int ctrl_slew_en_lsb = 6; // phase_slew_enable
	localparam int ctrl_zds_lsb = 7; // zero_delay_sync
	localparam int ctrl_pps0_lsb = 8; // input zero is one-pulse-per-second
	localparam int ctrl_pps1_lsb = 9;
	localparam int prio1_lsb = 4; // input one priority field
	localparam int mon_per_input = 5; // freq, miss, runt, phase, timer en
	localparam int slew_timer_lsb = 16;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] ctrl_reset = 32'h0000_0000;
	localparam logic [2:0] prio_reset = 3'h1;
	localparam logic [15:0] vtimer_reset = 16'h0010;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		auto_revertive,
		auto_non_revertive,
		manual_fallback,
		manual_holdover
	} sel_mode_e;

	typedef enum logic [1:0] {
		loop_free_run,
		loop_holdover,
		loop_locked
	} loop_state_e;

	// per-input monitor enables
	typedef struct packed {
		logic freq;
		logic miss;
		logic runt;
		logic phase;
		logic timer;
	} mon_en_s;

	// per-input raw monitor flags
	typedef struct packed {
		logic freq;
		logic miss;
		logic runt;
		logic phase;
	} mon_flag_s;

	// phase transient handling requested of the loop core
	typedef struct packed {
		logic cancel;
		logic slew;
		logic pass_fastlock;
	} hitless_s;

endpackage

// ===== ref_input_select_monitor.sv
// ref_input_select_monitor: qualifies two references and the oscillator,
// picks the active reference and steers hitless switching of the loop.
// assumes monitor flags, select pin and lock inputs are asynchronous pins
// What this block does
// - each input has priority 0 to 7, 0 excluded, 1 highest
// - equal priorities: input zero ranks ahead of input one
// - automatic priority selection, or manual by register or pin
// - auto revertive: switch at once to higher-priority valid input
// - auto non-revertive: keep current input until it turns invalid
// - manual choice from register field or pin, kept while valid
// - manual fallback: best valid input, else holdover or free-run
// - manual holdover: invalid manual input gives holdover or free-run
// - leave holdover as soon as selected input is valid again
// - slew limit on osc-only exit, holdover exit, unlocked switch
// - both off: phase offset passed at fast-lock bandwidth rate
// - cancellation: no phase step between frequency-locked inputs
// - pps switching is hitless only without zero-delay sync
// - frequency and phase-valid detectors never active together
// - oscillator loss flag clears inside the coarse range
// - oscillator bypass forces valid, loss flag unaffected
// - pps input uses only phase-valid monitor
// - disabled monitors raise no flag and are ignored
// - valid only after enabled monitors clear for validation time
// - status pins show all inputs, register shows selected input
`timescale 1ns/1ps
module ref_input_select_monitor
	import ref_select_pkg::*;
#(
	parameter int n_inputs = 2,
	parameter int timer_w = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [3:0] mon_flag_pin0,
	input wire logic [3:0] mon_flag_pin1,
	input wire logic osc_in_range,
	input wire logic manual_ref_pin,
	input wire logic history_valid,
	input wire logic freq_locked_pair,
	input wire logic loop_lock,
	output logic [n_inputs-1:0] active_ref,
	output logic [1:0] loop_state,
	output logic osc_freq_loss_flag,
	output logic osc_valid,
	output logic [3:0] status_pin0,
	output logic [3:0] status_pin1,
	output logic [2:0] hitless_ctl,
	output logic slew_request,
	output logic [15:0] phase_slew_threshold,
	output logic [15:0] phase_slew_timer
);

	// ----------------------------------------------------------------
	// checks and state
	// ----------------------------------------------------------------
	// elaboration checks: two inputs, timers of at most 16 bits
	if (n_inputs != 2) begin : bad_inputs
		$error("only two reference inputs are supported");
	end
	if (timer_w < 1 || timer_w > 16) begin : bad_timer
		$error("timer_w must be 1 to 16");
	end

	typedef struct packed {
		logic [31:0] ctrl;
		logic [7:0] prio;
		logic [9:0] mon_en;
		logic [15:0] vtime0;
		logic [15:0] vtime1;
		logic [31:0] slew;
		logic [3:0] sync0_a;
		logic [3:0] sync0_b;
		logic [3:0] sync1_a;
		logic [3:0] sync1_b;
		logic [4:0] misc_a; // range, pin, history, pairlock, lock
		logic [4:0] misc_b;
		logic [1:0] primed; // pin synchronisers hold real samples
		logic [15:0] count0;
		logic [15:0] count1;
		logic [1:0] valid;
		logic have_ref;
		logic sel; // 0 = input zero
		loop_state_e loop;
		logic osc_loss;
		logic slew_req;
		logic [31:0] rdata;
	} state_s;

	state_s q;
	state_s next_q;

	// ----------------------------------------------------------------
	// combinational views
	// ----------------------------------------------------------------
	sel_mode_e mode;
	mon_en_s en0;
	mon_en_s en1;
	mon_flag_s gate0;
	mon_flag_s gate1;
	logic [2:0] prio0;
	logic [2:0] prio1;
	logic best_ok;
	logic best_sel;
	logic man_sel;
	logic want_ok;
	logic want_sel;
	logic bad0;
	logic bad1;
	logic bus_wr;
	logic bus_rd;
	logic addr_ok;
	logic cur_ok;
	logic [15:0] vlim0;
	logic [15:0] vlim1;
	logic pps_any;
	hitless_s hitless;

	// only the low timer_w bits of a validation time take part
	localparam logic [15:0] vtime_mask = 16'hFFFF >> (16 - timer_w);

	assign mode = sel_mode_e'(q.ctrl[ctrl_mode_lsb +: 2]);
	assign prio0 = q.prio[2:0];
	assign prio1 = q.prio[prio1_lsb +: 3];
	assign bus_wr = psel && penable && pwrite;
	assign bus_rd = psel && !penable && !pwrite;

	// validation limits cut to the timer width
	assign vlim0 = q.vtime0 & vtime_mask;
	assign vlim1 = q.vtime1 & vtime_mask;

	// the held input stays usable only while valid and not excluded
	assign cur_ok = q.valid[q.sel] &&
		(q.sel ? prio1 : prio0) != 3'h0;

	// monitor enables: pps input keeps only the phase monitor, and the
	// phase monitor is dropped whenever the frequency monitor is on
	always_comb begin
		en0 = mon_en_s'(q.mon_en[0 +: mon_per_input]);
		en1 = mon_en_s'(q.mon_en[mon_per_input +: mon_per_input]);
		if (q.ctrl[ctrl_pps0_lsb]) begin
			en0.freq = 1'b0;
			en0.miss = 1'b0;
			en0.runt = 1'b0;
		end
		if (q.ctrl[ctrl_pps1_lsb]) begin
			en1.freq = 1'b0;
			en1.miss = 1'b0;
			en1.runt = 1'b0;
		end
		if (en0.freq)
			en0.phase = 1'b0;
		if (en1.freq)
			en1.phase = 1'b0;
		// runt detection rides on the missing-pulse window
		en0.runt = en0.runt && en0.miss;
		en1.runt = en1.runt && en1.miss;
	end

	// disabled monitors raise nothing
	assign gate0 = q.sync0_b & {en0.freq, en0.miss, en0.runt, en0.phase};
	assign gate1 = q.sync1_b & {en1.freq, en1.miss, en1.runt, en1.phase};
	assign bad0 = |gate0;
	assign bad1 = |gate1;

	// priority pick among valid inputs
	always_comb begin
		best_ok = 1'b0;
		best_sel = 1'b0;
		if (q.valid[0] && prio0 != 3'h0) begin
			best_ok = 1'b1;
			best_sel = 1'b0;
		end
		if (q.valid[1] && prio1 != 3'h0) begin
			// strictly better only; a tie keeps input zero
			if (!best_ok || prio1 < prio0) begin
				best_ok = 1'b1;
				best_sel = 1'b1;
			end
		end
	end

	// manual choice: register field or pin
	assign man_sel = q.ctrl[ctrl_pinsel_lsb] ? q.misc_b[3] :
		q.ctrl[ctrl_man_lsb];

	// wanted reference for each selection mode
	always_comb begin
		want_ok = 1'b0;
		want_sel = q.sel;
		case (mode)
			auto_revertive: begin
				want_ok = best_ok;
				want_sel = best_sel;
			end
			auto_non_revertive: begin
				if (q.have_ref && cur_ok) begin
					want_ok = 1'b1;
					want_sel = q.sel;
				end else begin
					want_ok = best_ok;
					want_sel = best_sel;
				end
			end
			manual_fallback: begin
				if (q.valid[man_sel]) begin
					want_ok = 1'b1;
					want_sel = man_sel;
				end else begin
					want_ok = best_ok;
					want_sel = best_sel;
				end
			end
			manual_holdover: begin
				want_ok = q.valid[man_sel];
				want_sel = man_sel;
			end
			default: begin
				want_ok = 1'b0;
				want_sel = q.sel;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		next_q = q;
		// two-flop synchronisers for pin inputs
		next_q.sync0_a = mon_flag_pin0;
		next_q.sync0_b = q.sync0_a;
		next_q.sync1_a = mon_flag_pin1;
		next_q.sync1_b = q.sync1_a;
		next_q.misc_a = {osc_in_range, manual_ref_pin, history_valid,
			freq_locked_pair, loop_lock};
		next_q.misc_b = q.misc_a;

		// validation timers per input
		if (bad0) begin
			next_q.valid[0] = 1'b0;
			next_q.count0 = 16'h0000;
		end else if (!en0.timer || q.count0 >= vlim0) begin
			next_q.valid[0] = 1'b1;
		end else begin
			next_q.count0 = q.count0 + 16'h0001;
		end
		if (bad1) begin
			next_q.valid[1] = 1'b0;
			next_q.count1 = 16'h0000;
		end else if (!en1.timer || q.count1 >= vlim1) begin
			next_q.valid[1] = 1'b1;
		end else begin
			next_q.count1 = q.count1 + 16'h0001;
		end

		// oscillator coarse-range loss flag, kept at its reset value
		// until the synchroniser carries a real pin sample
		next_q.primed = {q.primed[0], 1'b1};
		if (q.primed[1])
			next_q.osc_loss = !q.misc_b[4];

		// reference and loop state
		next_q.slew_req = 1'b0;
		if (want_ok) begin
			next_q.have_ref = 1'b1;
			next_q.sel = want_sel;
			next_q.loop = loop_locked;
			if (q.loop != loop_locked ||
				(q.sel != want_sel && !q.misc_b[1]))
				next_q.slew_req = q.ctrl[ctrl_slew_en_lsb];
		end else begin
			next_q.have_ref = 1'b0;
			next_q.loop = q.misc_b[2] ? loop_holdover :
				loop_free_run;
		end

		// register writes
		if (bus_wr) begin
			case (paddr)
				ctrl_addr: next_q.ctrl = pwdata;
				prio_addr: next_q.prio = pwdata[7:0];
				mon_en_addr: next_q.mon_en = pwdata[9:0];
				vtimer0_addr: next_q.vtime0 = pwdata[15:0];
				vtimer1_addr: next_q.vtime1 = pwdata[15:0];
				slew_addr: next_q.slew = pwdata;
				default: ;
			endcase
		end

		// read data captured in the setup cycle
		if (bus_rd) begin
			case (paddr)
				ctrl_addr: next_q.rdata = q.ctrl;
				prio_addr: next_q.rdata = {24'h000000, q.prio};
				mon_en_addr: next_q.rdata = {22'h000000, q.mon_en};
				vtimer0_addr: next_q.rdata = {16'h0000, q.vtime0};
				vtimer1_addr: next_q.rdata = {16'h0000, q.vtime1};
				slew_addr: next_q.rdata = q.slew;
				status_addr: next_q.rdata = {24'h000000, q.misc_b[0],
					q.osc_loss, q.valid, q.loop, q.have_ref, q.sel};
				flags_addr: next_q.rdata = {28'h0000000,
					q.sel ? gate1 : gate0};
				default: next_q.rdata = 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
			q.ctrl <= ctrl_reset;
			q.prio <= {1'b0, prio_reset, 1'b0, prio_reset};
			q.vtime0 <= vtimer_reset;
			q.vtime1 <= vtimer_reset;
			q.loop <= loop_free_run;
		end else begin
			q <= next_q;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	always_comb begin
		case (paddr)
			ctrl_addr, prio_addr, mon_en_addr, vtimer0_addr,
			vtimer1_addr, slew_addr, status_addr, flags_addr:
				addr_ok = 1'b1;
			default: addr_ok = 1'b0;
		endcase
	end

	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_ok;
	assign prdata = q.rdata;
	assign active_ref = q.have_ref ? (q.sel ? 2'b10 : 2'b01) : 2'b00;
	assign loop_state = q.loop;
	assign osc_freq_loss_flag = q.osc_loss;
	assign osc_valid = q.ctrl[ctrl_osc_byp_lsb] || !q.osc_loss;
	assign status_pin0 = gate0;
	assign status_pin1 = gate1;
	// pps mode of either input, for the zero-delay sync exception
	assign pps_any = q.ctrl[ctrl_pps0_lsb] || q.ctrl[ctrl_pps1_lsb];

	// cancel only between frequency-locked inputs and, for pps,
	// only without zero-delay sync
	assign hitless.cancel = q.ctrl[ctrl_cancel_lsb] && q.misc_b[1] &&
		!(q.ctrl[ctrl_zds_lsb] && pps_any);
	assign hitless.slew = q.ctrl[ctrl_slew_en_lsb];
	assign hitless.pass_fastlock = !q.ctrl[ctrl_cancel_lsb] &&
		!q.ctrl[ctrl_slew_en_lsb];
	assign hitless_ctl = hitless;
	assign slew_request = q.slew_req;
	assign phase_slew_threshold = q.slew[15:0];
	assign phase_slew_timer = q.slew[slew_timer_lsb +: 16];

endmodule

// ===== ref_select_assertions.sv
// ref_select_assertions: port checks of the reference selector
// assumes a bind onto ref_input_select_monitor, one pclk domain
`timescale 1ns/1ps
module ref_select_checker #(
	parameter int n_inputs = 2
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic osc_in_range,
	input wire logic [3:0] mon_flag_pin0,
	input wire logic [n_inputs-1:0] active_ref,
	input wire logic [1:0] loop_state,
	input wire logic osc_freq_loss_flag,
	input wire logic osc_valid,
	input wire logic [3:0] status_pin0,
	input wire logic slew_request
);
	// ------------------------------------------------------------
	// selection and qualification
	// ------------------------------------------------------------
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	one_ref_a: assert property ($onehot0(active_ref))
		else $error("more than one reference active");
	loss_set_a: assert property (!osc_in_range [*4] |-> osc_freq_loss_flag)
		else $error("loss flag not set");
	loss_clr_a: assert property (osc_in_range [*4] |-> !osc_freq_loss_flag)
		else $error("loss flag not cleared");
	osc_ok_a: assert property (!osc_freq_loss_flag |-> osc_valid)
		else $error("oscillator not valid");
	gate_off_a: assert property ((mon_flag_pin0 == 4'h0) [*3] |->
		status_pin0 == 4'h0)
		else $error("status pin without flag");
	drop_bad_a: assert property (status_pin0 != 4'h0 && active_ref[0] |-> ##[1:3] !active_ref[0])
		else $error("flagged input kept");
	qualify_a: assert property ($rose(active_ref[0]) |-> $past(status_pin0, 2) == 4'h0)
		else $error("input chosen while flagged");
	no_lock_a: assert property (active_ref == '0 |-> ##[0:1] loop_state != 2'h2)
		else $error("locked with no reference");
	slew_pulse_a: assert property (slew_request |=> !slew_request)
		else $error("slew request too long");
endmodule

// ===== ref_source_model.sv
// ref_source_model: two reference sources and the oscillator
// assumes fault commands from the bench, changes after pclk edges
`timescale 1ns/1ps
module ref_source_model (
	input wire logic pclk,
	input wire logic [1:0] fault,
	input wire logic runt0,
	input wire logic osc_ok,
	output logic [3:0] mon_flag_pin0,
	output logic [3:0] mon_flag_pin1,
	output logic osc_in_range
);
	// ------------------------------------------------------------
	// flags as seen by the monitors
	// ------------------------------------------------------------
	initial begin
		mon_flag_pin0 = 4'h0;
		mon_flag_pin1 = 4'h0;
		osc_in_range = 1'b1;
	end
	// healthy sources never flag, gaps included
	always @(posedge pclk) begin
		mon_flag_pin0 <= {fault[0], 1'b0, runt0, 1'b0};
		mon_flag_pin1 <= {fault[1], 3'h0};
		osc_in_range <= osc_ok;
	end
endmodule

// ===== ref_input_select_monitor_bench.sv
// ref_input_select_monitor_bench: self-checking bench
// assumes the package, the design, the source model and the checker
`timescale 1ns/1ps
module ref_input_select_monitor_bench;
	import ref_select_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, manual_ref_pin = 0, history_valid = 0;
	logic freq_locked_pair = 0, osc_ok = 1, runt0 = 0;
	logic loop_lock = 1;
	logic [1:0] fault = 2'h0, active_ref, loop_state, s, f_old;
	logic [3:0] fp0, fp1, status_pin0, status_pin1;
	logic [15:0] thr, tmr;
	logic osc_in_range, osc_valid, held = 0;
	logic [2:0] hitless_ctl, p0, p1;
	logic [32:0] exp_q[$];
	int n_mismatch = 0, n_compared = 0, seed = 32086;
	// ------------------------------------------------------------
	// clock, design, sources
	// ------------------------------------------------------------
	always #50 pclk = ~pclk;
	ref_input_select_monitor dut (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.mon_flag_pin0(fp0), .mon_flag_pin1(fp1), .osc_in_range,
		.manual_ref_pin, .history_valid, .freq_locked_pair, .loop_lock,
		.active_ref, .loop_state, .osc_freq_loss_flag(), .osc_valid,
		.status_pin0, .status_pin1, .hitless_ctl, .slew_request(),
		.phase_slew_threshold(thr), .phase_slew_timer(tmr));
	ref_source_model src (.pclk, .fault, .runt0, .osc_ok,
		.mon_flag_pin0(fp0), .mon_flag_pin1(fp1), .osc_in_range);
	task automatic check(input logic [32:0] got, input logic [32:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task tally_and_finish();
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task wt(input int c);
		repeat (c) @(posedge pclk);
	endtask
	// one apb transfer, held until pready
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	task rd(input logic [11:0] a, input logic [32:0] e);
		exp_q.push_back(e);
		apb(0, a, 32'h0);
	endtask
	// watcher takes the oldest note at each read access
	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite && exp_q.size() > 0)
			check({pslverr, prdata}, exp_q.pop_front());
	end
	// status word: lock, loss, valid, loop, have, sel
	function logic [32:0] st(input logic [1:0] hs, input logic [1:0] lp,
		input logic [1:0] v, input logic loss);
		return {25'h0, 1'b1, loss, v, lp, hs};
	endfunction
	function logic [1:0] pick(input logic [2:0] a, input logic [2:0] b,
		input logic [1:0] f);
		logic v0, v1;
		v0 = !f[0] && a != 3'h0;
		v1 = !f[1] && b != 3'h0;
		return {v0 | v1, v1 && (!v0 || b < a)};
	endfunction
	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		wt(20);
		presetn <= 1;
		@(posedge pclk);
		rd(ctrl_addr, {1'b0, ctrl_reset});
		rd(prio_addr, 33'h000000011);
		rd(vtimer0_addr, {17'h0, vtimer_reset});
		rd(12'h020, 33'h100000000);
		check({30'h0, hitless_ctl}, 33'h1);
		$display("test registers done");
		apb(1, mon_en_addr, 32'h231);
		apb(1, vtimer0_addr, 32'h28);
		apb(1, vtimer1_addr, 32'h4);
		apb(1, slew_addr, 32'h0005_0010);
		rd(slew_addr, 33'h000050010);
		check({1'b0, tmr, thr}, 33'h000050010);
		apb(1, ctrl_addr, 32'h40);
		for (int i = 0; i < 8; i++) begin
			p0 = 3'($random(seed));
			p1 = 3'($random(seed));
			f_old = fault;
			fault <= 2'($random(seed));
			history_valid <= 1'($random(seed));
			apb(1, prio_addr, {25'h0, p1, 1'b0, p0});
			wt(60);
			// new priorities meet old validity before faults land;
			// with no usable input the last choice is kept
			s = pick(p0, p1, f_old);
			if (s[1])
				held = s[0];
			s = pick(p0, p1, fault);
			if (s[1])
				held = s[0];
			rd(status_addr, st({s[1], held},
				s[1] ? 2'h2 : {1'b0, history_valid},
				~fault, 1'b0));
		end
		$display("test priority done");
		apb(1, prio_addr, 32'h21);
		fault <= 2'h0;
		apb(1, ctrl_addr, 32'h41);
		wt(60);
		fault <= 2'h1;
		wt(60);
		rd(status_addr, st(2'h3, 2'h2, 2'h2, 0));
		fault <= 2'h0;
		wt(20);
		rd(status_addr, st(2'h3, 2'h2, 2'h2, 0));
		wt(60);
		rd(status_addr, st(2'h3, 2'h2, 2'h3, 0));
		runt0 <= 1;
		apb(1, ctrl_addr, 32'h40);
		wt(10);
		rd(status_addr, st(2'h2, 2'h2, 2'h3, 0));
		check({29'h0, status_pin0}, 33'h0);
		runt0 <= 0;
		$display("test automatic done");
		history_valid <= 0;
		apb(1, ctrl_addr, 32'h4F);
		wt(10);
		rd(status_addr, st(2'h2, 2'h2, 2'h3, 0));
		fault <= 2'h1;
		wt(10);
		rd(status_addr, st(2'h0, 2'h0, 2'h2, 0));
		fault <= 2'h0;
		wt(60);
		rd(status_addr, st(2'h2, 2'h2, 2'h3, 0));
		apb(1, ctrl_addr, 32'h46);
		wt(10);
		fault <= 2'h2;
		wt(10);
		rd(status_addr, st(2'h2, 2'h2, 2'h1, 0));
		check({29'h0, status_pin1}, 33'h8);
		osc_ok <= 0;
		wt(10);
		check({32'h0, osc_valid}, 33'h0);
		apb(1, ctrl_addr, 32'h56);
		rd(status_addr, st(2'h2, 2'h2, 2'h1, 1));
		check({32'h0, osc_valid}, 33'h1);
		$display("test manual done");
		freq_locked_pair <= 1;
		apb(1, ctrl_addr, 32'h20);
		wt(2);
		check({30'h0, hitless_ctl}, 33'h4);
		apb(1, ctrl_addr, 32'h2A0);
		check({30'h0, hitless_ctl}, 33'h0);
		$display("test hitless done");
		wt(3);
		tally_and_finish();
	end
	initial begin
		wt(20000);
		n_mismatch++;
		tally_and_finish();
	end
endmodule
bind ref_input_select_monitor ref_select_checker #(.n_inputs(n_inputs))
	chk (.pclk, .presetn, .osc_in_range, .mon_flag_pin0, .active_ref,
	.loop_state, .osc_freq_loss_flag, .osc_valid, .status_pin0,
	.slew_request);
